// ---- bench/sram_ctrl_model.sv ----
`timescale 1ns/10ps
module sram_ctrl_model
  import sram_core_pkg::*;
(
  // Clock and mode
  input wire logic i_clk,
  input wire logic i_flowthru_sel_n,
  // Command and data toward the core
  output logic o_clk_en_n,
  output logic [2:0] o_sel,
  output logic o_write_n,
  output logic o_advance_load,
  output logic [sram_core_pkg::LANE_COUNT-1:0] o_byte_sel_n,
  output logic [sram_core_pkg::ADDR_W-1:0] o_addr_bus,
  output logic [sram_core_pkg::DATA_W-1:0] o_data
);
  // ----
  // Late write data queue
  // ----
  logic [DATA_W:0] pend [3];
  logic last_wr;

  initial begin
    o_clk_en_n = 1'b1;
    o_sel = 3'h7;
    o_write_n = 1'b1;
    o_advance_load = 1'b0;
    o_byte_sel_n = MASK_NONE;
    o_addr_bus = '0;
    o_data = '0;
    last_wr = 1'b0;
    pend = '{default: '0};
  end

  // Kind 0 read, 1 write, 2 continue, 3 read with given selects, 4 stall
  task automatic step(input logic [2:0] k, input logic [2:0] s, input logic [ADDR_W-1:0] a,
      input logic [LANE_COUNT-1:0] m, input logic [DATA_W-1:0] d);
    int lat;
    lat = i_flowthru_sel_n ? 2 : 1;
    o_clk_en_n = (k == 3'h4);
    if (k != 3'h4) begin
      if (k != 3'h2)
        last_wr = (k == 3'h1) && (s == 3'h2);
      pend[2] = pend[1];
      pend[1] = pend[0];
      pend[0] = {(k != 3'h0) && last_wr, d};
      o_sel = s;
      o_write_n = (k != 3'h1);
      o_advance_load = (k == 3'h2);
      o_byte_sel_n = m;
      o_addr_bus = a;
      // Nothing due: keep the line moving so a stale word never matches
      o_data = pend[lat][DATA_W] ? pend[lat][DATA_W-1:0] : ~o_data;
    end
    @(posedge i_clk);
    #1;
  endtask
endmodule // sram_ctrl_model

// ---- bench/sync_late_write_sram_core_bench.sv ----
`timescale 1ns/10ps
module sync_late_write_sram_core_bench import sram_core_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic out_en_n = 1'b0;
  logic flow_n = 1'b1;
  logic lin_n = 1'b1;
  logic sleep = 1'b0;
  logic cke_n, write_n, advance_load, oe_n, sleep_act, wr_rdy;
  logic [2:0] sel;
  logic [LANE_COUNT-1:0] bsel_n;
  logic [ADDR_W-1:0] addr, bb;
  logic [DATA_W-1:0] wdata, rdata;
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W:0] ex [3];
  logic [1:0] bn, bl;
  logic [2:0] dsel [3] = '{3'h6, 3'h0, 3'h3};
  int bad_count = 0;
  int n_checks = 0;
  int seq = 0;
  int cyc = 0;

  always #12.5 clk = ~clk;

  sram_ctrl_model ctl (.i_clk(clk), .i_flowthru_sel_n(flow_n), .o_clk_en_n(cke_n), .o_sel(sel),
    .o_write_n(write_n), .o_advance_load(advance_load), .o_byte_sel_n(bsel_n), .o_addr_bus(addr),
    .o_data(wdata));
  sync_late_write_sram_core DUT (.i_clk(clk), .i_sys_rst(rst), .i_clk_en_n(cke_n),
    .i_chip_sel1_n(sel[2]), .i_chip_sel2(sel[1]), .i_chip_sel3_n(sel[0]), .i_write_n(write_n),
    .i_advance_load(advance_load), .i_byte_sel_n(bsel_n), .i_addr_bus(addr), .i_data(wdata),
    .o_data(rdata), .o_data_oe_n(oe_n), .i_out_en_n(out_en_n), .i_flowthru_sel_n(flow_n),
    .i_linear_order_n(lin_n), .i_sleep_req(sleep), .i_drive_strength_sel(1'b0),
    .i_tie_high(1'b1), .i_tie_low(1'b0), .o_sleep_active(sleep_act), .o_wr_ready(wr_rdy));

  // ----
  // Checking and run control
  // ----
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp_data(input string nm, input logic [DATA_W-1:0] e,
      input logic [DATA_W-1:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  // Modes only change while reset is held
  task automatic do_reset(input logic f, input logic l);
    rst = 1'b1;
    flow_n = f;
    lin_n = l;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    ex = '{default: '0};
    bl = 2'h2;
  endtask

  task automatic op(input logic [2:0] k, input logic [2:0] s, input logic [ADDR_W-1:0] a,
      input logic [LANE_COUNT-1:0] m);
    logic [ADDR_W-1:0] ea;
    logic [DATA_W-1:0] d;
    int lat;
    ea = a;
    if (k == 3'h2) begin
      bn = bn + 2'h1;
      ea = {bb[ADDR_W-1:2], lin_n ? bb[1:0] ^ bn : bb[1:0] + bn};
    end else if (k != 3'h4) begin
      bb = a;
      bn = 2'h0;
      bl = (s == 3'h2 && k < 3'h2) ? k[1:0] : 2'h2;
    end
    d = {4{18'(seq * 37 + ea)}};
    seq++;
    if (k != 3'h4) begin
      if (bl == 2'h1)
        for (int i = 0; i < LANE_COUNT; i++)
          if (!m[i]) mem[ea][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
      ex[2] = ex[1];
      ex[1] = ex[0];
      ex[0] = {bl == 2'h0, (bl == 2'h0) ? mem[ea] : '0};
    end
    ctl.step(k, s, a, m, d);
    // Pipeline data shows after the next active edge, flow data at once
    lat = flow_n ? 1 : 0;
    cmp_bit("oe_n", !(ex[lat][DATA_W] && !out_en_n), oe_n);
    if (ex[lat][DATA_W] && !out_en_n)
      cmp_data("rdata", ex[lat][DATA_W-1:0], rdata);
    cmp_bit("wr_ready", 1'b1, wr_rdy);
  endtask

  task automatic idle(input int n);
    repeat (n) op(3'h3, 3'h7, '0, MASK_NONE);
  endtask

  task automatic nap(input int n);
    repeat (n) ctl.step(3'h3, 3'h7, '0, MASK_NONE, '0);
  endtask

  initial begin
    logic [ADDR_W-1:0] a;
    for (int c = 0; c < 4; c++) begin
      do_reset(c[1], c[0]);
      cmp_bit("rst_sleep", 1'b0, sleep_act);
      a = ADDR_W'(c * 64 + 4);
      op(3'h1, 3'h2, a, 8'h00);
      op(3'h1, 3'h2, a + 9, 8'h00);
      repeat (4) op(3'h2, 3'h2, '0, 8'h00);
      idle(3);
      op(3'h0, 3'h2, a + 9, MASK_NONE);
      repeat (4) op(3'h2, 3'h2, '0, MASK_NONE);
      op(3'h4, 3'h2, '0, MASK_NONE);
      op(3'h1, 3'h2, a + 9, 8'h5a);
      op(3'h4, 3'h2, '0, MASK_NONE);
      op(3'h0, 3'h2, a, MASK_NONE);
      foreach (dsel[j]) begin
        op(3'h1, dsel[j], a, 8'h00);
        op(3'h0, dsel[j], a, MASK_NONE);
      end
      op(3'h2, 3'h2, '0, 8'h00);
      for (int i = 0; i < LANE_COUNT; i++) op(3'h1, 3'h2, a, ~(8'h01 << i));
      op(3'h1, 3'h2, a, MASK_NONE);
      idle(3);
      op(3'h0, 3'h2, a, MASK_NONE);
      op(3'h0, 3'h2, a + 9, MASK_NONE);
      idle(2);
      out_en_n = 1'b1;
      op(3'h0, 3'h2, a, MASK_NONE);
      idle(3);
      out_en_n = 1'b0;
      sleep = 1'b1;
      nap(1);
      cmp_bit("sleep_early", 1'b0, sleep_act);
      nap(2);
      cmp_bit("sleep_on", 1'b1, sleep_act);
      cmp_bit("sleep_oe_n", 1'b1, oe_n);
      sleep = 1'b0;
      nap(3);
      cmp_bit("sleep_off", 1'b0, sleep_act);
      op(3'h0, 3'h2, a + 9, MASK_NONE);
      idle(3);
    end
    complete_run();
  end
endmodule // sync_late_write_sram_core_bench

// ---- rtl/sram_core_pkg.sv ----
package sram_core_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int LANE_COUNT = 8;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANE_COUNT * LANE_W;
  localparam int BURST_W = 2;
  localparam int WBUF_W = ADDR_W + LANE_COUNT + DATA_W;

  // ------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------
  localparam logic [LANE_COUNT-1:0] MASK_NONE = 8'hff;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam int SLEEP_ENTER_CYC = 2;
  localparam int SLEEP_EXIT_CYC = 2;
  localparam logic [1:0] SLEEP_ENTER_LAST = 2'(SLEEP_ENTER_CYC - 1);
  localparam logic [1:0] SLEEP_EXIT_LAST = 2'(SLEEP_EXIT_CYC - 1);

  // ------------------------------------------------------------
  // Kind of the burst in progress
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10
  } op_t;

endpackage

// ---- rtl/sync_late_write_sram_core.sv ----
// Functional notes
// - Clock enable high freezes command, burst and read state for that edge; sleep timer and write buffer still run.
// - Controls, address, data, sleep request sampled on rising edge; output enable, order not.
// - Selected only with chip_sel1_n low, chip_sel2 high, chip_sel3_n low.
// - Read starts on selected load edge with write strobe high; address latched.
// - Pipeline read data passes an output register: two-cycle latency.
// - Write starts on selected, enabled edge with write strobe low.
// - Each low byte select enables its own lane; any mix allowed.
// - Write with all byte selects high changes nothing.
// - Command edge registers selects, strobe, byte selects and address together.
// - Flow-through read data driven right after command edge.
// - Command decode and burst counter identical in both modes.
// - flowthru_sel_n low selects flow-through, high pipeline.
// - linear_order_n low selects linear burst, high interleaved.
// - sleep_req high requests low-power sleep.
// - Active-low output enable gates data drivers without the clock.
// - Two low address bits also preset the burst counter.
// - Eight byte lanes, each with its own byte select.
// - advance_load high steps two-bit burst counter, wraps after four.
// - Sleep entered two cycles after request rises, left two after fall.
// - Data drivers off during write cycles automatically.
// - Clock enable high keeps read bus driven, write bus released.
`timescale 1ns/10ps
module sync_late_write_sram_core
  import sram_core_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Command inputs
  input wire logic i_clk_en_n,
  input wire logic i_chip_sel1_n,
  input wire logic i_chip_sel2,
  input wire logic i_chip_sel3_n,
  input wire logic i_write_n,
  input wire logic i_advance_load,
  input wire logic [sram_core_pkg::LANE_COUNT-1:0] i_byte_sel_n,
  input wire logic [sram_core_pkg::ADDR_W-1:0] i_addr_bus,
  // Data pins, split into in, out and enable
  input wire logic [sram_core_pkg::DATA_W-1:0] i_data,
  output logic [sram_core_pkg::DATA_W-1:0] o_data,
  output logic o_data_oe_n,
  // Static mode inputs, asynchronous output enable, sampled sleep request
  input wire logic i_out_en_n,
  input wire logic i_flowthru_sel_n,
  input wire logic i_linear_order_n,
  input wire logic i_sleep_req,
  input wire logic i_drive_strength_sel,
  input wire logic i_tie_high,
  input wire logic i_tie_low,
  // Status
  output logic o_sleep_active,
  output logic o_wr_ready
);
  import sram_core_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    op_t last_op;
    logic [BURST_W-1:0] burst_base;
    logic [BURST_W-1:0] burst_cnt;
    logic [ADDR_W-1:0] s1_addr;
    logic s1_vld;
    logic s1_wr;
    logic [LANE_COUNT-1:0] s1_mask;
    logic [ADDR_W-1:0] s2_addr;
    logic s2_vld;
    logic s2_wr;
    logic [LANE_COUNT-1:0] s2_mask;
    logic rd1_vld;
    logic [DATA_W-1:0] rd1_data;
    logic rd2_vld;
    logic [DATA_W-1:0] rd2_data;
    logic [1:0] sleep_cnt;
    logic asleep;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  logic flow_mode;
  logic active_edge;
  logic selected;
  logic cmd_load;
  logic cmd_adv;
  logic cmd_read;
  logic cmd_write;
  logic access;
  logic [ADDR_W-1:0] cur_addr;
  logic [BURST_W-1:0] next_cnt;
  logic wr_take;
  logic [ADDR_W-1:0] wr_addr;
  logic [LANE_COUNT-1:0] wr_mask;
  logic buf_in_valid;
  logic buf_out_valid;
  logic [WBUF_W-1:0] buf_out;
  logic drive_vld;

  // Burst address: linear adds, interleaved xors
  function automatic logic [BURST_W-1:0] burst_low(input logic [BURST_W-1:0] base,
                                                    input logic [BURST_W-1:0] cnt,
                                                    input logic linear_n);
    burst_low = linear_n ? (base ^ cnt) : (base + cnt);
  endfunction

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  assign flow_mode = ~i_flowthru_sel_n;
  // Sleep stalls like clock enable so nothing is lost across it
  assign active_edge = ~i_clk_en_n && ~st.asleep;
  assign selected = ~i_chip_sel1_n && i_chip_sel2 && ~i_chip_sel3_n;
  assign cmd_load = active_edge && ~i_advance_load && selected;
  assign cmd_read = cmd_load && i_write_n;
  assign cmd_write = cmd_load && ~i_write_n;
  // Continue cycles reuse the kind of burst loaded last; continue after deselect stays idle
  assign cmd_adv = active_edge && i_advance_load && (st.last_op != OP_IDLE);
  assign access = cmd_load || cmd_adv;
  assign next_cnt = st.burst_cnt + BURST_STEP;
  assign cur_addr = cmd_load ? i_addr_bus :
    {st.s1_addr[ADDR_W-1:BURST_W], burst_low(st.burst_base, next_cnt, i_linear_order_n)};

  // ------------------------------------------------------------
  // Late write data pickup
  // ------------------------------------------------------------
  assign wr_take = active_edge &&
    (flow_mode ? (st.s1_vld && st.s1_wr) : (st.s2_vld && st.s2_wr));
  assign wr_addr = flow_mode ? st.s1_addr : st.s2_addr;
  assign wr_mask = flow_mode ? st.s1_mask : st.s2_mask;
  assign buf_in_valid = wr_take && (wr_mask != MASK_NONE);

  wdata_buffer #(
    .WIDTH(WBUF_W)
  ) u_wbuf (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(buf_in_valid),
    .i_in_data({wr_addr, wr_mask, i_data}),
    .o_in_ready(o_wr_ready),
    .o_out_valid(buf_out_valid),
    .o_out_data(buf_out),
    .i_out_ready(~st.asleep)
  );

  // Core write, lane by lane
  always_ff @(posedge i_clk) begin
    if (buf_out_valid && ~st.asleep) begin
      for (int i = 0; i < LANE_COUNT; i++) begin
        if (~buf_out[DATA_W+i]) begin
          mem[buf_out[WBUF_W-1 -: ADDR_W]][i*LANE_W +: LANE_W] <=
            buf_out[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (active_edge) begin
      next_st.s1_vld = access;
      next_st.s1_wr = cmd_load ? ~i_write_n : (st.last_op == OP_WRITE);
      next_st.s1_mask = i_byte_sel_n;
      next_st.s1_addr = cur_addr;
      next_st.s2_vld = st.s1_vld;
      next_st.s2_wr = st.s1_wr;
      next_st.s2_mask = st.s1_mask;
      next_st.s2_addr = st.s1_addr;
      if (cmd_load) begin
        next_st.burst_base = i_addr_bus[BURST_W-1:0];
        next_st.burst_cnt = BURST_ZERO;
        next_st.last_op = i_write_n ? OP_READ : OP_WRITE;
      end else if (cmd_adv) begin
        next_st.burst_cnt = next_cnt;
      end else if (~i_advance_load) begin
        next_st.last_op = OP_IDLE;
      end
      next_st.rd1_vld = access && (cmd_load ? i_write_n : (st.last_op == OP_READ));
      next_st.rd1_data = mem[cur_addr];
      next_st.rd2_vld = st.rd1_vld;
      next_st.rd2_data = st.rd1_data;
    end
    // Sleep timer runs on every edge, clock enable or not
    if (i_sleep_req != st.asleep) begin
      if (st.sleep_cnt == (st.asleep ? SLEEP_EXIT_LAST : SLEEP_ENTER_LAST)) begin
        next_st.asleep = i_sleep_req;
        next_st.sleep_cnt = 2'h0;
      end else begin
        next_st.sleep_cnt = st.sleep_cnt + 2'h1;
      end
    end else begin
      next_st.sleep_cnt = 2'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st <= '0;
      st.s1_mask <= MASK_NONE;
      st.s2_mask <= MASK_NONE;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Output drivers
  // ------------------------------------------------------------
  // Drive strength and tie inputs only matter to the pads
  assign drive_vld = flow_mode ? st.rd1_vld : st.rd2_vld;
  assign o_data = flow_mode ? st.rd1_data : st.rd2_data;
  assign o_data_oe_n = ~(drive_vld && ~i_out_en_n && ~st.asleep);
  assign o_sleep_active = st.asleep;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_stall_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_clk_en_n && ~i_sleep_req && ~st.asleep |=> $stable(st.s1_addr) && $stable(st.rd2_vld)
  ) else $error("state moved while clock enable was high");

  chk_desel_no_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    active_edge && ~i_advance_load && ~selected |=> ~st.rd1_vld && ~st.s1_vld
  ) else $error("deselected load started an access");

  chk_pipe_read_lat: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ~flow_mode && cmd_read ##1 ~i_clk_en_n && ~st.asleep && $stable(i_flowthru_sel_n)
    |=> st.rd2_vld
  ) else $error("pipeline read data not ready at second edge");

  chk_flow_read_lat: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    flow_mode && cmd_read ##1 $stable(i_flowthru_sel_n) |-> drive_vld
  ) else $error("flow read data not ready after first edge");

  chk_pipe_wr_edge: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ~flow_mode && cmd_write ##1 active_edge ##1 active_edge && ~flow_mode |-> wr_take
  ) else $error("pipeline write data not taken at third edge");

  chk_flow_wr_edge: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    flow_mode && cmd_write ##1 active_edge && flow_mode |-> wr_take
  ) else $error("flow write data not taken at second edge");

  chk_abort_no_push: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ~flow_mode && cmd_write && (i_byte_sel_n == MASK_NONE) ##1 active_edge ##1 active_edge
    |-> ~buf_in_valid
  ) else $error("write abort reached the core");

  chk_write_no_drive: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ~flow_mode && cmd_write ##1 active_edge |=> o_data_oe_n
  ) else $error("drivers on during write data phase");

  chk_burst_wrap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cmd_load ##1 cmd_adv [*4] |=> st.s1_addr[BURST_W-1:0] == st.burst_base
  ) else $error("burst did not wrap after four accesses");

  chk_sleep_enter: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(i_sleep_req) && ~st.asleep ##1 i_sleep_req |=> st.asleep
  ) else $error("sleep not entered two cycles after request");

  chk_sleep_exit: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(i_sleep_req) && st.asleep ##1 ~i_sleep_req |=> ~st.asleep
  ) else $error("sleep not left two cycles after release");

  chk_abort_flow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    flow_mode && cmd_write && (i_byte_sel_n == MASK_NONE) ##1 active_edge |-> ~buf_in_valid
  ) else $error("flow write abort reached the core");

  chk_oe_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_out_en_n |-> o_data_oe_n
  ) else $error("data drivers on with output enable high");

  chk_sleep_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    st.asleep |-> o_data_oe_n && ~buf_in_valid
  ) else $error("activity while asleep");

  chk_desel_cont: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    active_edge && ~i_advance_load && ~selected ##1 active_edge && i_advance_load
    |=> ~st.s1_vld && ~st.rd1_vld
  ) else $error("continue after deselect started an access");

  chk_load_addr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cmd_load |=> st.s1_addr == $past(i_addr_bus)
      && st.burst_base == $past(i_addr_bus[BURST_W-1:0])
  ) else $error("loaded address not latched");

  chk_mask_pair: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cmd_write |=> st.s1_wr && st.s1_mask == $past(i_byte_sel_n)
  ) else $error("write controls not registered together");

  chk_write_cont: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cmd_write ##1 cmd_adv |=> st.s1_wr && ~st.rd1_vld
  ) else $error("write burst continue did not write");

  chk_read_cont: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cmd_read ##1 cmd_adv |=> st.rd1_vld && ~st.s1_wr
  ) else $error("read burst continue did not read");

endmodule // sync_late_write_sram_core

// ---- rtl/wdata_buffer.sv ----
`timescale 1ns/10ps
module wdata_buffer #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] ent;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
  } buf_state_t;

  buf_state_t st;
  buf_state_t next_st;
  logic push;
  logic pop;

  assign o_in_ready = (st.count != 2'h2);
  assign o_out_valid = (st.count != 2'h0);
  assign o_out_data = st.ent[st.rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.ent[st.wr_ptr] = i_in_data;
      next_st.wr_ptr = ~st.wr_ptr;
    end
    if (pop) begin
      next_st.rd_ptr = ~st.rd_ptr;
    end
    next_st.count = st.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  chk_buf_no_overfill: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_in_valid |-> o_in_ready) else $error("write word offered to full buffer");

endmodule // wdata_buffer
